// >>> design/adc_conversion_sequencer.sv
// Conversion sequencer for a 10-bit successive-approximation converter,
// with its registers behind an AXI4-Lite slave.
// Assumes an external analog front end: comparator, trial DAC, mux.
`timescale 1ns/1ps
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Marks the current bus read as a DMA transfer
  input  wire logic        dma_controller_read,
  // External trigger and analog front end
  input  wire logic        external_trigger_pin,
  input  wire logic        comparator_high,
  output logic [2:0]       analog_channel_sel,
  output logic             sample_hold,
  output logic [9:0]       dac_trial_code,
  // Interrupt request
  output logic             conversion_end_interrupt
);

  function automatic logic [9:0] samp_len(input logic conversion_clock_select);
    return conversion_clock_select ? SAMP_F : SAMP_S;
  endfunction : samp_len

  function automatic logic [9:0] conv_len(input logic conversion_clock_select,
                                          input logic first);
    if (first)
      return conversion_clock_select ? CONV_FIRST_F : CONV_FIRST_S;
    return conversion_clock_select ? CONV_NEXT_F : CONV_NEXT_S;
  endfunction : conv_len

  function automatic logic [9:0] dly_len(input logic conversion_clock_select,
                                         input logic [3:0] ph);
    return conversion_clock_select ? DLY_MIN_F + {7'h00, ph[2:0]} : DLY_MIN_S + {6'h00, ph};
  endfunction : dly_len

  function automatic logic [2:0] group_first(input logic [2:0] ch,
                                             input logic multi);
    return multi ? {ch[2], 2'h0} : ch;
  endfunction : group_first

  // Register state
  logic             end_flag_ff;
  logic             irq_en_ff;
  logic             start_ff;
  logic             multi_ff;
  logic             cks_ff;
  logic [2:0]       ch_ff;
  logic             trge_hi_ff;
  logic             trge_lo_ff;
  logic             scan_ff;
  logic             flag_read_ff;
  logic [9:0]       result_ff [4];
  // Sequencer state
  conv_state_t      st_ff;
  logic [9:0]       cnt_ff;
  logic [3:0]       phase_ff;
  logic             first_ff;
  logic [2:0]       ch_cur_ff;
  logic [9:0]       trial_ff;
  logic [3:0]       idx_ff;
  logic [3:0]       step_ff;
  logic             sar_busy_ff;
  logic             trig_prev_ff;
  // Bus state
  logic             aw_held_ff;
  logic             w_held_ff;
  logic [7:0]       awaddr_ff;
  logic [31:0]      wdata_ff;
  logic             wstrb0_ff;
  logic             bvalid_ff;
  logic [1:0]       bresp_ff;
  logic             rvalid_ff;
  logic [31:0]      rdata_ff;
  logic [1:0]       rresp_ff;

  logic             wr_fire;
  logic             rd_fire;
  logic             csr_wr;
  logic             start_req;
  logic             abort;
  logic             trig_fire;
  logic             cnv_done;
  logic             seq_end;
  logic             eff_multi;
  logic             eff_cks;
  logic [2:0]       eff_ch;
  logic             wr_mapped;
  logic             rd_mapped;
  logic [31:0]      rd_word;
  logic             dma_clr;
  logic [9:0]       nxt_trial;

  assign awready = !aw_held_ff;
  assign wready  = !w_held_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = !rvalid_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;

  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign rd_fire = arvalid && !rvalid_ff;
  assign wr_mapped = awaddr_ff[1:0] == 2'h0 && awaddr_ff <= RES3_OFS;
  assign rd_mapped = araddr[1:0] == 2'h0 && araddr <= RES3_OFS;
  assign csr_wr  = wr_fire && wstrb0_ff && awaddr_ff == CSR_OFS;

  // A write that sets start also carries the settings it runs with
  assign eff_multi = csr_wr ? wdata_ff[CSR_MULTI_BIT] : multi_ff;
  assign eff_cks   = csr_wr ? wdata_ff[CSR_CKS_BIT] : cks_ff;
  assign eff_ch    = csr_wr ? wdata_ff[CSR_CH_LSB +: 3] : ch_ff;

  assign trig_fire = trge_hi_ff && trge_lo_ff && trig_prev_ff
                     && !external_trigger_pin;
  // Trigger start shares the software start path exactly
  assign start_req = !start_ff && (trig_fire
                     || (csr_wr && wdata_ff[CSR_START_BIT]));
  assign abort     = start_ff && csr_wr && !wdata_ff[CSR_START_BIT];
  assign cnv_done  = st_ff == ST_CONV && cnt_ff == 10'h000 && !abort;
  // Multi group count-1 sits in the low channel bits, so the last
  // channel always equals the channel field itself
  assign seq_end   = cnv_done && ch_cur_ff == ch_ff;
  assign dma_clr   = rd_fire && dma_controller_read
                     && araddr >= RES0_OFS && rd_mapped;

  assign analog_channel_sel = ch_cur_ff;
  assign sample_hold        = st_ff == ST_SAMPLE;
  assign dac_trial_code     = trial_ff;
  assign conversion_end_interrupt = end_flag_ff && irq_en_ff;

  // Read mux; reserved bits read as zero, low trigger bits as one
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (araddr)
      CSR_OFS:  rd_word[7:0] = {end_flag_ff, irq_en_ff, start_ff, multi_ff,
                                cks_ff, ch_ff};
      TRIG_OFS: rd_word[7:0] = {trge_hi_ff, trge_lo_ff, scan_ff, 5'h00}
                               | TRIG_ONES;
      8'h08:    rd_word[9:0] = result_ff[0];
      8'h0C:    rd_word[9:0] = result_ff[1];
      8'h10:    rd_word[9:0] = result_ff[2];
      8'h14:    rd_word[9:0] = result_ff[3];
      default:  rd_word = 32'h0000_0000;
    endcase
  end

  // Write path: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb0_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      if (awvalid && !aw_held_ff) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= awaddr;
      end
      if (wvalid && !w_held_ff) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= wdata;
        wstrb0_ff <= wstrb[0];
      end
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read path: one cycle from address handshake to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Settings registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_ff  <= CSR_RESET[CSR_IE_BIT];
      multi_ff   <= CSR_RESET[CSR_MULTI_BIT];
      cks_ff     <= CSR_RESET[CSR_CKS_BIT];
      ch_ff      <= CSR_RESET[CSR_CH_LSB +: 3];
      trge_hi_ff <= TRIG_RESET[TRIG_HI_BIT];
      trge_lo_ff <= TRIG_RESET[TRIG_LO_BIT];
      scan_ff    <= TRIG_RESET[TRIG_SCAN_BIT];
    end else if (wr_fire && wstrb0_ff) begin
      if (awaddr_ff == CSR_OFS) begin
        irq_en_ff <= wdata_ff[CSR_IE_BIT];
        multi_ff  <= eff_multi;
        cks_ff    <= eff_cks;
        ch_ff     <= eff_ch;
      end else if (awaddr_ff == TRIG_OFS) begin
        trge_hi_ff <= wdata_ff[TRIG_HI_BIT];
        trge_lo_ff <= wdata_ff[TRIG_LO_BIT];
        scan_ff    <= wdata_ff[TRIG_SCAN_BIT];
      end
    end
  end

  // Start bit: a new start outranks the self clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn)
      start_ff <= CSR_RESET[CSR_START_BIT];
    else if (start_req)
      start_ff <= 1'b1;
    else if (abort)
      start_ff <= 1'b0;
    else if (seq_end && !(multi_ff && scan_ff))
      start_ff <= 1'b0;
  end

  // End flag: a write clear needs a prior read of the flag at 1, a DMA result read clears at once; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      end_flag_ff  <= CSR_RESET[CSR_FLAG_BIT];
      flag_read_ff <= 1'b0;
    end else begin
      if (seq_end)
        end_flag_ff <= 1'b1;
      else if ((csr_wr && !wdata_ff[CSR_FLAG_BIT] && flag_read_ff)
               || dma_clr)
        end_flag_ff <= 1'b0;
      if (rd_fire && araddr == CSR_OFS && end_flag_ff)
        flag_read_ff <= 1'b1;
      else if (csr_wr)
        flag_read_ff <= 1'b0;
    end
  end

  // Free phase counter; a write lands at any phase, spreading the delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_ff     <= 4'h0;
      trig_prev_ff <= 1'b1;
    end else begin
      phase_ff     <= (phase_ff == PHASE_WRAP) ? 4'h0 : phase_ff + 4'h1;
      trig_prev_ff <= external_trigger_pin;
    end
  end

  // Sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff     <= ST_IDLE;
      cnt_ff    <= 10'h000;
      first_ff  <= 1'b0;
      ch_cur_ff <= 3'h0;
    end else if (abort) begin
      st_ff <= ST_IDLE;
    end else if (start_req) begin
      st_ff     <= ST_DELAY;
      cnt_ff    <= dly_len(eff_cks, phase_ff) - 10'h001;
      first_ff  <= 1'b1;
      ch_cur_ff <= group_first(eff_ch, eff_multi);
    end else begin
      unique case (st_ff)
        ST_IDLE: ;
        ST_DELAY: begin
          cnt_ff <= cnt_ff - 10'h001;
          if (cnt_ff == 10'h000) begin
            st_ff  <= ST_SAMPLE;
            cnt_ff <= samp_len(cks_ff) - 10'h001;
          end
        end
        ST_SAMPLE: begin
          cnt_ff <= cnt_ff - 10'h001;
          if (cnt_ff == 10'h000) begin
            st_ff  <= ST_CONV;
            cnt_ff <= conv_len(cks_ff, first_ff) - 10'h001;
          end
        end
        ST_CONV: begin
          cnt_ff <= cnt_ff - 10'h001;
          if (cnv_done) begin
            first_ff <= 1'b0;
            if (seq_end && !(multi_ff && scan_ff)) begin
              st_ff <= ST_IDLE;
            end else begin
              st_ff     <= ST_SAMPLE;
              cnt_ff    <= samp_len(cks_ff) - 10'h001;
              ch_cur_ff <= seq_end ? group_first(ch_ff, 1'b1)
                                   : ch_cur_ff + 3'h1;
            end
          end
        end
      endcase
    end
  end

  // Result store; channels 4..7 fold onto the same four registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++)
        result_ff[i] <= 10'h000;
    end else if (cnv_done) begin
      result_ff[ch_cur_ff[1:0]] <= trial_ff;
    end
  end

  // Successive approximation, MSB first; keeps the bit while the
  // comparator says the input is at or above the trial code
  always_comb begin
    nxt_trial = trial_ff;
    nxt_trial[idx_ff] = comparator_high;
    if (idx_ff != 4'h0)
      nxt_trial[idx_ff - 4'h1] = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trial_ff    <= 10'h000;
      idx_ff      <= SAR_MSB;
      step_ff     <= 4'h0;
      sar_busy_ff <= 1'b0;
    end else if (st_ff == ST_SAMPLE && cnt_ff == 10'h000) begin
      trial_ff    <= SAR_INIT;
      idx_ff      <= SAR_MSB;
      step_ff     <= 4'h0;
      sar_busy_ff <= 1'b1;
    end else if (st_ff == ST_CONV && sar_busy_ff) begin
      if (step_ff == (cks_ff ? SAR_STEP_F : SAR_STEP_S) - 4'h1) begin
        trial_ff <= nxt_trial;
        step_ff  <= 4'h0;
        idx_ff   <= idx_ff - 4'h1;
        if (idx_ff == 4'h0)
          sar_busy_ff <= 1'b0;
      end else begin
        step_ff <= step_ff + 4'h1;
      end
    end
  end

  // Checking helpers: cycles since a conversion began and in sampling
  logic [9:0] tot_h;
  logic [9:0] samp_h;
  logic [9:0] dly_h;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tot_h  <= 10'h000;
      samp_h <= 10'h000;
      dly_h  <= 10'h000;
    end else begin
      tot_h  <= (start_req || cnv_done) ? 10'h001 : tot_h + 10'h001;
      samp_h <= (st_ff == ST_SAMPLE) ? samp_h + 10'h001 : 10'h000;
      dly_h  <= (st_ff == ST_DELAY) ? dly_h + 10'h001 : 10'h000;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence single_end_s;
    cnv_done && !multi_ff && !csr_wr;
  endsequence
  sequence group_end_s;
    seq_end && multi_ff && !csr_wr;
  endsequence

  single_self_clear_a: assert property (single_end_s |=>
      !start_ff && end_flag_ff && st_ff == ST_IDLE)
    else $error("single end did not clear start or set flag");
  end_irq_a: assert property (seq_end && irq_en_ff
      && !csr_wr |=> conversion_end_interrupt)
    else $error("end interrupt not raised");
  flag_clear_src_a: assert property ($fell(end_flag_ff) |->
      $past(dma_clr) || ($past(csr_wr) && $past(flag_read_ff)))
    else $error("end flag cleared without read then write");
  group_first_ch_a: assert property ($rose(start_ff) && multi_ff |->
      ch_cur_ff == {ch_ff[2], 2'h0} && st_ff == ST_DELAY)
    else $error("multi start not at group first channel");
  next_ch_a: assert property (cnv_done && !seq_end |=>
      st_ff == ST_SAMPLE && ch_cur_ff == $past(ch_cur_ff) + 3'h1)
    else $error("next channel did not follow at once");
  multi_stop_a: assert property (group_end_s and !scan_ff |=>
      !start_ff && end_flag_ff ##1 st_ff == ST_IDLE)
    else $error("multi group end mishandled");
  scan_wrap_a: assert property (group_end_s and scan_ff |=>
      start_ff && end_flag_ff && st_ff == ST_SAMPLE
      && ch_cur_ff == {ch_ff[2], 2'h0})
    else $error("scan pass did not restart at first channel");
  sample_len_a: assert property (st_ff == ST_SAMPLE
      && cnt_ff == 10'h000 && !abort |->
      samp_h == samp_len(cks_ff) - 10'h001)
    else $error("sampling window length wrong");
  delay_range_a: assert property (st_ff == ST_DELAY
      && cnt_ff == 10'h000 && !abort |->
      (cks_ff ? (dly_h + 10'h001 >= DLY_MIN_F && dly_h < DLY_MAX_F)
              : (dly_h + 10'h001 >= DLY_MIN_S && dly_h < DLY_MAX_S)))
    else $error("start delay out of range");
  conv_time_a: assert property (cnv_done |-> (first_ff
      ? (cks_ff ? (tot_h >= FIRST_MIN_F && tot_h <= FIRST_MAX_F)
                : (tot_h >= FIRST_MIN_S && tot_h <= FIRST_MAX_S))
      : tot_h == (cks_ff ? NEXT_F : NEXT_S)))
    else $error("conversion time out of range");
  // The halting write may also clear an armed flag, so only a rise is wrong
  abort_quiet_a: assert property (abort |=> st_ff == ST_IDLE
      && !start_ff && !$rose(end_flag_ff) ##1 !$rose(end_flag_ff))
    else $error("abort changed flag or kept running");
  trig_start_a: assert property (trig_fire && !start_ff
      && !csr_wr |=> start_ff && st_ff == ST_DELAY)
    else $error("trigger edge did not start conversion");

endmodule : adc_conversion_sequencer

// >>> design/adc_seq_pkg.sv
// Package for the conversion sequencer: register map, field positions,
// reset values, sequencer states and timing counts in clock states.
// Assumes one clock, where one state equals one clock period.
package adc_seq_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] CSR_OFS  = 8'h00;
  localparam logic [7:0] TRIG_OFS = 8'h04;
  localparam logic [7:0] RES0_OFS = 8'h08;
  localparam logic [7:0] RES3_OFS = 8'h14;

  // Control/status field positions
  localparam int CSR_FLAG_BIT  = 7;
  localparam int CSR_IE_BIT    = 6;
  localparam int CSR_START_BIT = 5;
  localparam int CSR_MULTI_BIT = 4;
  localparam int CSR_CKS_BIT   = 3;
  localparam int CSR_CH_LSB    = 0;

  // Trigger control field positions
  localparam int TRIG_HI_BIT   = 7;
  localparam int TRIG_LO_BIT   = 6;
  localparam int TRIG_SCAN_BIT = 5;

  // Reset values; low three trigger bits always read as ones
  localparam logic [7:0] CSR_RESET  = 8'h00;
  localparam logic [7:0] TRIG_RESET = 8'h07;
  localparam logic [7:0] TRIG_ONES  = 8'h07;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing in states (clock cycles)
  localparam logic [9:0] DLY_MIN_S   = 10'h011;
  localparam logic [9:0] DLY_MAX_S   = 10'h01C;
  localparam logic [9:0] DLY_MIN_F   = 10'h00A;
  localparam logic [9:0] DLY_MAX_F   = 10'h011;
  localparam logic [9:0] SAMP_S      = 10'h081;
  localparam logic [9:0] SAMP_F      = 10'h041;
  localparam logic [9:0] FIRST_MIN_S = 10'h202;
  localparam logic [9:0] FIRST_MAX_S = 10'h20D;
  localparam logic [9:0] FIRST_MIN_F = 10'h103;
  localparam logic [9:0] FIRST_MAX_F = 10'h10A;
  localparam logic [9:0] NEXT_S      = 10'h100;
  localparam logic [9:0] NEXT_F      = 10'h080;
  localparam logic [9:0] CONV_FIRST_S = FIRST_MIN_S - DLY_MIN_S - SAMP_S;
  localparam logic [9:0] CONV_FIRST_F = FIRST_MIN_F - DLY_MIN_F - SAMP_F;
  localparam logic [9:0] CONV_NEXT_S  = NEXT_S - SAMP_S;
  localparam logic [9:0] CONV_NEXT_F  = NEXT_F - SAMP_F;
  localparam logic [3:0] PHASE_WRAP   = 4'(DLY_MAX_S - DLY_MIN_S);
  localparam logic [3:0] SAR_STEP_S   = 4'hC;
  localparam logic [3:0] SAR_STEP_F   = 4'h6;
  localparam logic [3:0] SAR_MSB      = 4'h9;
  localparam logic [9:0] SAR_INIT     = 10'h200;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_DELAY  = 4'h2,
    ST_SAMPLE = 4'h4,
    ST_CONV   = 4'h8
  } conv_state_t;

endpackage : adc_seq_pkg

// >>> testbench/analog_front_model.sv
// Analog front end model: eight fixed input levels, a sample-and-hold
// and an ideal comparator. Assumes the sequencer drives mux and trial.
`timescale 1ns/1ps
module analog_front_model (
  // Clock
  input  wire logic        aclk,
  // Sequencer side
  input  wire logic [2:0]  analog_channel_sel,
  input  wire logic        sample_hold,
  input  wire logic [9:0]  dac_trial_code,
  output logic             comparator_high,
  // Levels from the bench, ten bits a channel
  input  wire logic [79:0] analog_level
);
  logic [9:0] held_ff = 10'h000;

  // Held value follows the mux only in the window, so a late mux move
  // cannot disturb a conversion in flight
  always_ff @(posedge aclk) begin
    if (sample_hold) begin
      held_ff <= analog_level[analog_channel_sel*10 +: 10];
    end
  end
  assign comparator_high = (held_ff >= dac_trial_code);
endmodule : analog_front_model

// >>> testbench/tb_top.sv
// Bench for the conversion sequencer: AXI4-Lite tasks, single, multi,
// triggered scan, aborts and flag clearing. Assumes the package map.
`timescale 1ns/1ps
module tb_top
  import adc_seq_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        dma_rd = 1'b0;
  logic        trig = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, cmp_hi, s_h, irq;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [2:0]  ch_sel;
  logic [9:0]  dac;
  logic [79:0] levels = {10'h30C, 10'h0F0, 10'h1FF, 10'h200,
                         10'h001, 10'h3FF, 10'h2AA, 10'h155};
  int          fail_count = 0;
  int          checked = 0;
  int          n, d, k;

  always #50 aclk = ~aclk;

  adc_conversion_sequencer u_adc_conversion_sequencer (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .dma_controller_read(dma_rd), .external_trigger_pin(trig),
    .comparator_high(cmp_hi), .analog_channel_sel(ch_sel),
    .sample_hold(s_h), .dac_trial_code(dac),
    .conversion_end_interrupt(irq));

  analog_front_model u_analog_front_model (
    .aclk(aclk), .analog_channel_sel(ch_sel), .sample_hold(s_h),
    .dac_trial_code(dac), .comparator_high(cmp_hi),
    .analog_level(levels));

  function automatic logic [31:0] lv(input int ch);
    return 32'(levels[ch*10 +: 10]);
  endfunction : lv

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_rng(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("[ERR] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : cmp_rng

  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    logic ad, wd, bd;
    ad = 1'b0;
    wd = 1'b0;
    bd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bd) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        bd = 1'b1;
        rs = bresp;
        bready <= 1'b0;
      end
    end
  endtask : wr

  task automatic rd_reg(input logic [7:0] a, input logic dm);
    logic ad, dn;
    ad = 1'b0;
    dn = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    dma_rd <= dm;
    while (!dn) begin
      @(posedge aclk);
      if (!ad && arready) begin
        ad = 1'b1;
        arvalid <= 1'b0;
        dma_rd <= 1'b0;
      end
      if (rvalid) begin
        dn = 1'b1;
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
      end
    end
  endtask : rd_reg

  // Counts edges until the interrupt or the sample window shows lvl
  task automatic wait_on(input bit use_irq, input logic lvl, input int lim);
    n = 0;
    while ((use_irq ? irq : s_h) !== lvl && n < lim) begin
      @(posedge aclk);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      $display("[ERR] %0t wait limit reached", $time);
    end
  endtask : wait_on

  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(CSR_OFS, 1'b0);
    cmp_val(rd, 32'(CSR_RESET));
    cmp_val(32'(rs), 32'(RESP_OKAY));
    rd_reg(TRIG_OFS, 1'b0);
    cmp_val(rd, 32'(TRIG_RESET));
    rd_reg(8'h18, 1'b0);
    cmp_val(32'(rs), 32'(RESP_SLVERR));
    wr(8'h18, 32'h0000_0000);
    cmp_val(32'(rs), 32'(RESP_SLVERR));
    // Single, channel 1, fast clock, interrupt on
    wr(CSR_OFS, 32'h69);
    wait_on(1'b0, 1'b1, 100);
    d = n;
    cmp_rng(n, int'(DLY_MIN_F) - 2, int'(DLY_MAX_F));
    wait_on(1'b0, 1'b0, 200);
    cmp_rng(n, int'(SAMP_F), int'(SAMP_F));
    d = d + n;
    wait_on(1'b1, 1'b1, 400);
    cmp_rng(d + n, int'(FIRST_MIN_F) - 2, int'(FIRST_MAX_F));
    rd_reg(RES0_OFS + 8'h04, 1'b0);
    cmp_val(rd, lv(1));
    wr(CSR_OFS, 32'h49);
    rd_reg(CSR_OFS, 1'b0);
    cmp_val(rd, 32'hC9);
    wr(CSR_OFS, 32'h49);
    rd_reg(CSR_OFS, 1'b0);
    cmp_val(rd, 32'h49);
    cmp_val(32'(irq), 32'h0);
    // Multi, group 1, three channels, slow clock
    wr(TRIG_OFS, 32'h00);
    cmp_val(32'(rs), 32'(RESP_OKAY));
    wr(CSR_OFS, 32'h36);
    wait_on(1'b0, 1'b1, 100);
    cmp_val(32'(ch_sel), 32'h4);
    wait_on(1'b0, 1'b0, 200);
    wait_on(1'b0, 1'b1, 500);
    cmp_val(32'(ch_sel), 32'h5);
    wait_on(1'b0, 1'b0, 200);
    d = n;
    wait_on(1'b0, 1'b1, 300);
    cmp_rng(d + n, int'(NEXT_S), int'(NEXT_S));
    k = 0;
    rd_reg(CSR_OFS, 1'b0);
    while (rd[CSR_START_BIT] !== 1'b0 && k < 400) begin
      rd_reg(CSR_OFS, 1'b0);
      k++;
    end
    cmp_val(rd, 32'h96);
    cmp_val(32'(irq), 32'h0);
    for (int c = 0; c < 3; c++) begin
      rd_reg(RES0_OFS + 8'(4 * c), 1'b0);
      cmp_val(rd, lv(4 + c));
    end
    // Scan, group 0, two channels, fast clock, started by the trigger
    wr(CSR_OFS, 32'h59);
    wr(TRIG_OFS, 32'hE0);
    trig <= 1'b0;
    repeat (4) @(posedge aclk);
    trig <= 1'b1;
    wait_on(1'b1, 1'b1, 1000);
    wait_on(1'b0, 1'b1, 10);
    cmp_val(32'(ch_sel), 32'h0);
    rd_reg(CSR_OFS, 1'b0);
    cmp_val(rd, 32'hF9);
    rd_reg(RES0_OFS, 1'b0);
    cmp_val(rd, lv(0));
    rd_reg(RES0_OFS + 8'h04, 1'b0);
    cmp_val(rd, lv(1));
    wr(CSR_OFS, 32'h59);
    repeat (600) @(posedge aclk);
    rd_reg(CSR_OFS, 1'b0);
    cmp_val(rd, 32'h59);
    wr(CSR_OFS, 32'h79);
    wait_on(1'b0, 1'b1, 100);
    cmp_val(32'(ch_sel), 32'h0);
    wr(CSR_OFS, 32'h59);
    // Single channel 2 abandoned in its sampling window
    wr(CSR_OFS, 32'h2A);
    wait_on(1'b0, 1'b1, 100);
    cmp_val(32'(ch_sel), 32'h2);
    wr(CSR_OFS, 32'h0A);
    repeat (400) @(posedge aclk);
    rd_reg(RES0_OFS + 8'h08, 1'b0);
    cmp_val(rd, lv(6));
    rd_reg(CSR_OFS, 1'b0);
    cmp_val(rd, 32'h0A);
    // Single channel 3, flag cleared by a DMA result read
    wr(CSR_OFS, 32'h6B);
    wait_on(1'b1, 1'b1, 400);
    cmp_val(32'(irq), 32'h1);
    rd_reg(RES3_OFS, 1'b1);
    cmp_val(rd, lv(3));
    @(posedge aclk);
    cmp_val(32'(irq), 32'h0);
    wrap_up();
  end

  // Whole run needs well under 8000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule : tb_top
